/* cimr_irq_route.sv */
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
// Operation
// - global source reaches a line only when its mask bit is one
// - mask registers written only in protected-write mode; reads always allowed
// - mask bit 17 enables the mailbox time-out interrupt
// - mask bit 16 enables the time-stamp overflow interrupt
// - bits 14,13,12 enable abort-ack, write-denied and wake-up
// - bits 11..8 enable msg-lost, bus-off, error-passive, warning
// - reserved mask bits ignore writes and read as zero
// - bit 2 steers all global interrupts to line 1 or line 0
// - bit 1 is master enable of line 1
// - bit 0 is master enable of line 0
// - mailbox flag gated by its per-mailbox mask bit and the master enable of its line
// - one flag per mailbox, transmit or receive by its direction
// - mailbox mask holds one enable per mailbox, zero at reset
// - masked-in mailbox raises interrupt after good transfer
// - level bit n routes mailbox n to line 0 or 1, reset zero
// - vector reports highest pending mailbox, 31 ranked highest
// - compat mode uses vector bits 3:0, mailboxes 16..31 ignored
module cimr_irq_route
  import cimr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic protected_write_mode_i,
  input wire logic compat_mode_i,
  input wire logic [31:0] global_flag_i,
  input wire logic [31:0] mailbox_flag_i,
  output logic global_mailbox_flag_o,
  output logic [4:0] mailbox_vector_o,
  output logic irq_line0_o,
  output logic irq_line1_o
);

  logic [31:0] global_irq_mask_reg_ff;
  logic [31:0] mailbox_irq_mask_reg_ff;
  logic [31:0] mailbox_irq_level_reg_ff;
  logic [31:0] nxt_rd;
  logic [31:0] wr_bits;
  logic [31:0] mbx_act;
  logic [31:0] mbx_valid;
  logic [31:0] gsrc_act;
  logic [4:0] nxt_vec;
  logic any_g, any_m0, any_m1, l0, l1, wb_req, wr_en;
  // named fields of the global mask
  logic timeout_irq_en;
  logic stamp_overflow_irq_en;
  logic abort_ack_irq_en;
  logic write_denied_irq_en;
  logic wakeup_irq_en;
  logic msg_lost_irq_en;
  logic busoff_irq_en;
  logic err_passive_irq_en;
  logic warn_level_irq_en;
  logic global_line_select;
  logic line1_master_enable;
  logic line0_master_enable;

  // highest numbered set bit, mailbox 31 first
  function automatic logic [4:0] top_bit(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: single-cycle ack, drops the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_req & wb_we_i & protected_write_mode_i;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // byte-merged write value for the global mask
  assign wr_bits = merge(global_irq_mask_reg_ff, wb_dat_i, wb_sel_i);

  // global mask register, reserved bits never stored
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      global_irq_mask_reg_ff <= CIMR_REG_RST;
    end else if (wr_en && wb_adr_i == CIMR_GIM_OFS) begin
      global_irq_mask_reg_ff <= wr_bits & CIMR_GIM_WMASK;
    end
  end

  // mailbox mask register
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mailbox_irq_mask_reg_ff <= CIMR_REG_RST;
    end else if (wr_en && wb_adr_i == CIMR_MIM_OFS) begin
      mailbox_irq_mask_reg_ff <= merge(mailbox_irq_mask_reg_ff, wb_dat_i,
                                       wb_sel_i);
    end
  end

  // mailbox level register, also under protected write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mailbox_irq_level_reg_ff <= CIMR_REG_RST;
    end else if (wr_en && wb_adr_i == CIMR_MIL_OFS) begin
      mailbox_irq_level_reg_ff <= merge(mailbox_irq_level_reg_ff, wb_dat_i,
                                        wb_sel_i);
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    nxt_rd = 32'h0000_0000;
    case (wb_adr_i)
      CIMR_GIM_OFS: nxt_rd = global_irq_mask_reg_ff;
      CIMR_MIM_OFS: nxt_rd = mailbox_irq_mask_reg_ff;
      CIMR_MIL_OFS: nxt_rd = mailbox_irq_level_reg_ff;
      CIMR_VEC_OFS: nxt_rd = {26'h0, global_mailbox_flag_o,
                              mailbox_vector_o};
      default: nxt_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      wb_dat_o <= nxt_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mailbox flags: one per mailbox, set on tx done or rx good
  // compat mode drops mailboxes 16..31
  assign mbx_valid = compat_mode_i ? 32'h0000_ffff : 32'hffff_ffff;
  assign mbx_act = mailbox_flag_i & mbx_valid;
  assign nxt_vec = top_bit(mbx_act);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mailbox_vector_o <= 5'h00;
      global_mailbox_flag_o <= 1'b0;
    end else begin
      mailbox_vector_o <= nxt_vec;
      global_mailbox_flag_o <= |mbx_act;
    end
  end

  // field decode of the global mask, used by the checks below
  assign timeout_irq_en = global_irq_mask_reg_ff[CIMR_TIMEOUT_BIT];
  assign stamp_overflow_irq_en = global_irq_mask_reg_ff[CIMR_OVF_BIT];
  assign abort_ack_irq_en = global_irq_mask_reg_ff[CIMR_ABORT_BIT];
  assign write_denied_irq_en = global_irq_mask_reg_ff[CIMR_WDEN_BIT];
  assign wakeup_irq_en = global_irq_mask_reg_ff[CIMR_WAKE_BIT];
  assign msg_lost_irq_en = global_irq_mask_reg_ff[CIMR_LOST_BIT];
  assign busoff_irq_en = global_irq_mask_reg_ff[CIMR_BOFF_BIT];
  assign err_passive_irq_en = global_irq_mask_reg_ff[CIMR_EPAS_BIT];
  assign warn_level_irq_en = global_irq_mask_reg_ff[CIMR_WARN_BIT];
  assign global_line_select = global_irq_mask_reg_ff[CIMR_GSEL_BIT];
  assign line1_master_enable = global_irq_mask_reg_ff[CIMR_L1EN_BIT];
  assign line0_master_enable = global_irq_mask_reg_ff[CIMR_L0EN_BIT];

  // global sources gated by their own mask bits
  assign gsrc_act = global_flag_i & global_irq_mask_reg_ff
                    & CIMR_GSRC_MASK;
  assign any_g = |gsrc_act;
  // mailbox gating by per-mailbox mask only, routed by level bits
  assign any_m0 = |(mbx_act & mailbox_irq_mask_reg_ff
                    & ~mailbox_irq_level_reg_ff);
  assign any_m1 = |(mbx_act & mailbox_irq_mask_reg_ff
                    & mailbox_irq_level_reg_ff);

  // line combine with global steering and master enables
  assign l0 = global_irq_mask_reg_ff[CIMR_L0EN_BIT] & (any_m0 |
              (any_g & ~global_irq_mask_reg_ff[CIMR_GSEL_BIT]));
  assign l1 = global_irq_mask_reg_ff[CIMR_L1EN_BIT] & (any_m1 |
              (any_g & global_irq_mask_reg_ff[CIMR_GSEL_BIT]));

  // registered interrupt lines
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_line0_o <= 1'b0;
      irq_line1_o <= 1'b0;
    end else begin
      irq_line0_o <= l0;
      irq_line1_o <= l1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_line0_disable: assert property (@(posedge mclk_i) disable iff (srst_i)
    !global_irq_mask_reg_ff[CIMR_L0EN_BIT] |=> !irq_line0_o)
    else $error("line 0 active while disabled");
  a_line1_disable: assert property (@(posedge mclk_i) disable iff (srst_i)
    !global_irq_mask_reg_ff[CIMR_L1EN_BIT] |=> !irq_line1_o)
    else $error("line 1 active while disabled");
  a_write_protect: assert property (@(posedge mclk_i) disable iff (srst_i)
    !protected_write_mode_i |=> $stable(mailbox_irq_mask_reg_ff))
    else $error("mailbox mask changed without protected mode");
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_irq_mask_reg_ff & ~CIMR_GIM_WMASK) == 32'h0)
    else $error("reserved mask bit set");
  a_global_route: assert property (@(posedge mclk_i) disable iff (srst_i)
    (any_g && global_irq_mask_reg_ff[CIMR_GSEL_BIT]
     && global_irq_mask_reg_ff[CIMR_L1EN_BIT]) |=> irq_line1_o)
    else $error("global source not on line 1");
  a_masked_global: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_BOFF_BIT] && !global_irq_mask_reg_ff[CIMR_BOFF_BIT])
    |-> !gsrc_act[CIMR_BOFF_BIT])
    else $error("masked bus-off passed");
  a_mbx_line0: assert property (@(posedge mclk_i) disable iff (srst_i)
    (any_m0 && global_irq_mask_reg_ff[CIMR_L0EN_BIT]) |=> irq_line0_o)
    else $error("mailbox not on line 0");
  a_compat_vec: assert property (@(posedge mclk_i) disable iff (srst_i)
    compat_mode_i |=> !mailbox_vector_o[4])
    else $error("compat vector above 15");
  a_vector_top: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!compat_mode_i && mailbox_flag_i[31]) |=> mailbox_vector_o == 5'h1f)
    else $error("mailbox 31 not ranked highest");
  a_ack_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (@(posedge mclk_i) disable iff (srst_i)
    wb_req |=> wb_ack_o)
    else $error("request not acknowledged");

  ////////////////////////////////////////////////////////////////////////
  // per-source gating: an enabled flag reaches the global source OR
  a_timeout_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_TIMEOUT_BIT] && timeout_irq_en) |-> any_g)
    else $error("enabled time-out not passed");
  a_timeout_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    !timeout_irq_en |-> !gsrc_act[CIMR_TIMEOUT_BIT])
    else $error("masked time-out passed");
  a_ovf_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_OVF_BIT] && stamp_overflow_irq_en) |-> any_g)
    else $error("enabled overflow not passed");
  a_ovf_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    !stamp_overflow_irq_en |-> !gsrc_act[CIMR_OVF_BIT])
    else $error("masked overflow passed");
  a_abort_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_ABORT_BIT] && abort_ack_irq_en) |-> any_g)
    else $error("enabled abort-ack not passed");
  a_wden_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_WDEN_BIT] && write_denied_irq_en) |-> any_g)
    else $error("enabled write-denied not passed");
  a_wake_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_WAKE_BIT] && wakeup_irq_en) |-> any_g)
    else $error("enabled wake-up not passed");
  a_wake_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    !wakeup_irq_en |-> !gsrc_act[CIMR_WAKE_BIT])
    else $error("masked wake-up passed");
  a_lost_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_LOST_BIT] && msg_lost_irq_en) |-> any_g)
    else $error("enabled msg-lost not passed");
  a_boff_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_BOFF_BIT] && busoff_irq_en) |-> any_g)
    else $error("enabled bus-off not passed");
  a_epas_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_EPAS_BIT] && err_passive_irq_en) |-> any_g)
    else $error("enabled error-passive not passed");
  a_warn_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    (global_flag_i[CIMR_WARN_BIT] && warn_level_irq_en) |-> any_g)
    else $error("enabled warning not passed");
  a_warn_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    !warn_level_irq_en |-> !gsrc_act[CIMR_WARN_BIT])
    else $error("masked warning passed");
  a_unused_src: assert property (@(posedge mclk_i) disable iff (srst_i)
    (gsrc_act & ~CIMR_GSRC_MASK) == 32'h0)
    else $error("unmapped global source passed");

  ////////////////////////////////////////////////////////////////////////
  // line steering and quiet lines
  a_global_line0: assert property (@(posedge mclk_i) disable iff (srst_i)
    (any_g && !global_line_select && line0_master_enable)
    |=> irq_line0_o)
    else $error("global source not on line 0");
  a_mbx_line1: assert property (@(posedge mclk_i) disable iff (srst_i)
    (any_m1 && line1_master_enable) |=> irq_line1_o)
    else $error("mailbox not on line 1");
  a_line0_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!any_m0 && !(any_g && !global_line_select)) |=> !irq_line0_o)
    else $error("line 0 active with no source");
  a_line1_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!any_m1 && !(any_g && global_line_select)) |=> !irq_line1_o)
    else $error("line 1 active with no source");
  a_mbx_masked: assert property (@(posedge mclk_i) disable iff (srst_i)
    (mailbox_irq_mask_reg_ff == 32'h0) |-> (!any_m0 && !any_m1))
    else $error("masked mailbox raised interrupt");
  a_reset_quiet: assert property (@(posedge mclk_i)
    srst_i |=> (!irq_line0_o && !irq_line1_o && !wb_ack_o))
    else $error("outputs active after reset");

  ////////////////////////////////////////////////////////////////////////
  // write protection of the other registers, vector and flag
  a_gim_protect: assert property (@(posedge mclk_i) disable iff (srst_i)
    !protected_write_mode_i |=> $stable(global_irq_mask_reg_ff))
    else $error("global mask changed without protected mode");
  a_mil_protect: assert property (@(posedge mclk_i) disable iff (srst_i)
    !protected_write_mode_i |=> $stable(mailbox_irq_level_reg_ff))
    else $error("level register changed without protected mode");
  a_compat_high: assert property (@(posedge mclk_i) disable iff (srst_i)
    compat_mode_i |-> mbx_act[31:16] == 16'h0)
    else $error("upper mailbox counted in compat mode");
  a_gmf_level: assert property (@(posedge mclk_i) disable iff (srst_i)
    (|mbx_act) |=> global_mailbox_flag_o)
    else $error("mailbox flag not reported");
  a_vec_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
    (mbx_act == 32'h0) |=> (mailbox_vector_o == 5'h00
                            && !global_mailbox_flag_o))
    else $error("vector not idle with no flag");

endmodule
`default_nettype wire

/* cimr_pkg.sv */
`default_nettype none
package cimr_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [3:0] CIMR_GIM_OFS = 4'h0;
  localparam logic [3:0] CIMR_MIM_OFS = 4'h4;
  localparam logic [3:0] CIMR_MIL_OFS = 4'h8;
  localparam logic [3:0] CIMR_VEC_OFS = 4'hc;
  localparam logic [3:0] CIMR_IST_OFS = 4'h0 + 4'h0;
  // global mask field positions
  localparam int CIMR_TIMEOUT_BIT = 17;
  localparam int CIMR_OVF_BIT = 16;
  localparam int CIMR_ABORT_BIT = 14;
  localparam int CIMR_WDEN_BIT = 13;
  localparam int CIMR_WAKE_BIT = 12;
  localparam int CIMR_LOST_BIT = 11;
  localparam int CIMR_BOFF_BIT = 10;
  localparam int CIMR_EPAS_BIT = 9;
  localparam int CIMR_WARN_BIT = 8;
  localparam int CIMR_GSEL_BIT = 2;
  localparam int CIMR_L1EN_BIT = 1;
  localparam int CIMR_L0EN_BIT = 0;
  // writable bits of the global mask; reserved bits stay zero
  localparam logic [31:0] CIMR_GIM_WMASK = 32'h0003_7f07;
  // global event sources gated by the mask (bits 17,16,14..8)
  localparam logic [31:0] CIMR_GSRC_MASK = 32'h0003_7f00;
  localparam logic [31:0] CIMR_REG_RST = 32'h0000_0000;
  localparam int CIMR_NMBX = 32;
  localparam int CIMR_NMBX_COMPAT = 16;
endpackage
`default_nettype wire

/* cimr_flag_src.sv */
`default_nettype none
// flag owner: holds event levels until it is reloaded
module cimr_flag_src (
  input wire logic mclk_i,
  input wire logic load_i,
  input wire logic [31:0] gset_i,
  input wire logic [31:0] mset_i,
  output logic [31:0] gflag_o,
  output logic [31:0] mflag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags change only on a load, never cleared by the router
  always_ff @(posedge mclk_i) begin
    if (load_i) begin
      gflag_o <= gset_i;
      mflag_o <= mset_i;
    end
  end
endmodule
`default_nettype wire

/* test_can_interrupt_mask_routing.sv */
`default_nettype none
module test_can_interrupt_mask_routing
  import cimr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, srst_i = 1, cyc = 0, stb = 0, we = 0, pw = 0, cm = 0;
  logic ld = 1, ack, l0, l1, gmf;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [4:0] vec;
  logic [31:0] dat = 0, gs = 0, ms = 0, gf, mf, rd, r, gim = 0, mailbox_enable_bits = 0;
  logic [31:0] mailbox_line_bits = 0;
  logic [3:0] ra [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
  int miscompares = 0, samples_checked = 0, seed = 46, cyc_n = 0;
  ////////////////////////////////////////////////////////////////////////
  cimr_irq_route i_cimr_irq_route (.mclk_i(mclk_i), .srst_i(srst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .protected_write_mode_i(pw), .compat_mode_i(cm), .global_flag_i(gf),
    .mailbox_flag_i(mf), .global_mailbox_flag_o(gmf),
    .mailbox_vector_o(vec), .irq_line0_o(l0), .irq_line1_o(l1));
  cimr_flag_src i_cimr_flag_src (.mclk_i(mclk_i), .load_i(ld),
    .gset_i(gs), .mset_i(ms), .gflag_o(gf), .mflag_o(mf));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // expected {line1, line0}
  function automatic logic [1:0] exp_l(input logic c);
    logic [31:0] mv;
    logic g;
    mv = ms & mailbox_enable_bits & (c ? 32'h0000_ffff : 32'hffff_ffff);
    g = |(gs & gim & CIMR_GSRC_MASK);
    exp_l[1] = gim[1] & ((g & gim[2]) | (|(mv & mailbox_line_bits)));
    exp_l[0] = gim[0] & ((g & ~gim[2]) | (|(mv & ~mailbox_line_bits)));
  endfunction
  // expected {mailbox flag, vector}, mailbox 31 first
  function automatic logic [5:0] exp_v(input logic c);
    logic [31:0] mv;
    exp_v = 6'h00;
    mv = ms & (c ? 32'h0000_ffff : 32'hffff_ffff);
    for (int i = 0; i < 32; i++) begin
      if (mv[i]) exp_v = {1'b1, 5'(i)};
    end
  endfunction
  // byte-lane merge of a write
  function automatic logic [31:0] bmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    bmerge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) bmerge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic wishbone single cycle
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, ack, 1'b1);
    end
    q = rd;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge mclk_i);
  endtask
  task summarize;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic p, c;
    logic [31:0] d;
    repeat (16) @(posedge mclk_i);
    srst_i <= 0;
    ld <= 0;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      wb(0, ra[i], 0, r);
      chk(r, 0);
    end
    for (int k = 0; k < 150; k++) begin
      if (k == 75) begin
        srst_i <= 1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 0;
        gim = 0;
        mailbox_enable_bits = 0;
        mailbox_line_bits = 0;
        @(posedge mclk_i);
        chk({30'h0, l1, l0}, 32'h0);
      end
      p = $random(seed);
      c = $random(seed);
      pw <= p;
      cm <= c;
      d = (k % 10 == 0) ? 32'hffff_ffff : $random(seed);
      wb(1, CIMR_GIM_OFS, d, r);
      if (p) gim = d & CIMR_GIM_WMASK;
      d = $random(seed);
      sel <= d[7:4];
      d = $random(seed);
      wb(1, CIMR_MIM_OFS, d, r);
      if (p) mailbox_enable_bits = bmerge(mailbox_enable_bits, d, sel);
      d = $random(seed);
      sel <= 4'hf;
      wb(1, CIMR_MIL_OFS, d, r);
      if (p) mailbox_line_bits = d;
      wb(0, CIMR_GIM_OFS, 0, r);
      chk(r, gim);
      wb(0, CIMR_MIM_OFS, 0, r);
      chk(r, mailbox_enable_bits);
      wb(0, CIMR_MIL_OFS, 0, r);
      chk(r, mailbox_line_bits);
      gs <= $random(seed) & $random(seed) & $random(seed);
      ms <= $random(seed) & $random(seed) & $random(seed);
      ld <= 1;
      @(posedge mclk_i);
      ld <= 0;
      repeat (3) @(posedge mclk_i);
      chk({30'h0, l1, l0}, {30'h0, exp_l(c)});
      chk({26'h0, gmf, vec}, {26'h0, exp_v(c)});
      wb(0, CIMR_VEC_OFS, 0, r);
      chk(r, {26'h0, exp_v(c)});
    end
    summarize();
  end
endmodule
`default_nettype wire
